// File: inc/event_flags_pkg.sv
// constants shared by the event flag register block
// assumes a single 100 MHz system clock and an internal byte-wide register port
`default_nettype none

package event_flags_pkg;

  localparam int REG_ADDR_W = 8;
  localparam int REG_DATA_W = 8;

  // register offsets on the internal register port
  localparam logic [7:0] CHARGER_EVENT_FLAGS_OFFSET = 8'h08;
  localparam logic [7:0] POWER_PATH_EVENT_FLAGS_OFFSET = 8'h09;
  localparam logic [7:0] LINK_EVENT_FLAGS_OFFSET = 8'h0A;
  localparam logic [7:0] LINK_STATUS_OFFSET = 8'h03;

  // reset values
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] LINK_STATUS_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // widths of the multi-bit monitored fields
  localparam int CHG_MODE_W = 3;
  localparam int TEMP_ZONE_W = 3;

  // charger_event_flags bit positions
  localparam int SUM_LIMIT_ACTIVE_BIT = 7;
  localparam int SUMMED_CURRENT_BIT = 6;
  localparam int CHARGER_THERMAL_BIT = 5;
  localparam int CONST_CURRENT_TIMEOUT_BIT = 4;
  localparam int CHARGER_MODE_BIT = 3;
  localparam int SYS_MIN_VOLTAGE_BIT = 2;
  localparam int CHARGER_RESTART_BIT = 1;
  localparam int TEMP_ZONE_BIT = 0;

  // power_path_event_flags bit positions
  localparam int TEMP_ZONE_ADJUST_BIT = 7;
  localparam int CHARGER_REVERSE_BIT = 6;
  localparam int BATTERY_VOLTAGE_REG_BIT = 5;
  localparam int STEP_CHARGE_BIT = 4;
  localparam int CHARGER_DROPOUT_BIT = 3;
  localparam int SYS_REGULATOR_DROPOUT_BIT = 2;
  localparam int LINK_VOLTAGE_BIT = 1;
  localparam int SYS_REVERSE_BIT = 0;

  // link_event_flags bit positions
  localparam int LINK_CONNECTED_BIT = 7;
  localparam int LINK_WAITING_BIT = 6;
  localparam int LINK_IDLE_BIT = 5;
  localparam int SHORT_XFER_RISE_BIT = 4;
  localparam int SHORT_XFER_FALL_BIT = 3;
  localparam int NEW_DATA_BIT = 2;
  localparam int CMD_DONE_BIT = 1;
  localparam int CMD_ERROR_BIT = 0;

endpackage : event_flags_pkg

`default_nettype wire

// File: core/change_detect.sv
// level change detector for a vector of status signals
// assumes the sampled levels are synchronous to clk_sys
`default_nettype none

module change_detect #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rose,
  output logic [WIDTH-1:0] fell
);

  logic [WIDTH-1:0] prev_reg;
  logic [WIDTH-1:0] prev_next;
  logic armed_reg;
  logic armed_next;

  always_comb begin
    prev_next = level;
    armed_next = 1'b1;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prev_reg <= '0;
      armed_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
      armed_reg <= armed_next;
    end
  end

  // the first cycle after reset only captures the levels, so a status that
  // is already high at power up does not raise a spurious flag
  always_comb begin
    rose = armed_reg ? (level & ~prev_reg) : '0;
    fell = armed_reg ? (~level & prev_reg) : '0;
  end

endmodule : change_detect

`default_nettype wire

// File: core/event_flag_registers.sv
// three sticky event flag registers plus the latched link result code
// assumes status levels and event pulses are synchronous to clk_sys and
// that the serial register front end presents one-cycle read/write strobes
`default_nettype none

module event_flag_registers
  import event_flags_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic [event_flags_pkg::REG_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [event_flags_pkg::REG_DATA_W-1:0] reg_wdata,
  output logic [event_flags_pkg::REG_DATA_W-1:0] reg_rdata,
  // charger status levels
  input wire logic sum_limit_active_state,
  input wire logic summed_current_state,
  input wire logic charger_thermal_state,
  input wire logic const_current_timeout_state,
  input wire logic [event_flags_pkg::CHG_MODE_W-1:0] charger_mode_state,
  input wire logic sys_min_voltage_state,
  input wire logic charger_restart_state,
  input wire logic [event_flags_pkg::TEMP_ZONE_W-1:0] temp_zone_state,
  // power path status levels
  input wire logic temp_zone_adjust_state,
  input wire logic charger_reverse_state,
  input wire logic battery_voltage_reg_state,
  input wire logic step_charge_state,
  input wire logic charger_dropout_state,
  input wire logic sys_regulator_dropout_state,
  input wire logic link_voltage_present,
  input wire logic sys_reverse_state,
  // link status levels and events
  input wire logic link_connected_state,
  input wire logic link_waiting_state,
  input wire logic link_idle_state,
  input wire logic short_xfer_state,
  input wire logic new_data_stored,
  input wire logic cmd_done_pulse,
  input wire logic cmd_error_pulse,
  input wire logic [7:0] cmd_result,
  // flag and status outputs
  output logic [7:0] charger_event_flags,
  output logic [7:0] power_path_event_flags,
  output logic [7:0] link_event_flags,
  output logic [7:0] link_status
);

  import event_flags_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // set wins over clear so an event in the clearing cycle is not lost
  function automatic logic [7:0] sticky_update(input logic [7:0] cur,
                                               input logic [7:0] set,
                                               input logic [7:0] clr);
    sticky_update = (cur & ~clr) | set;
  endfunction : sticky_update

  function automatic logic any_bit(input logic [7:0] v);
    any_bit = |v;
  endfunction : any_bit

  ////////////////////////////////////////////////////////////////////////////
  // change detection over all monitored levels

  localparam int MON_W = 20 + CHG_MODE_W + TEMP_ZONE_W;

  logic [MON_W-1:0] mon_level;
  logic [MON_W-1:0] mon_rose;
  logic [MON_W-1:0] mon_fell;
  logic [MON_W-1:0] mon_chg;

  always_comb begin
    mon_level = {sum_limit_active_state, summed_current_state,
                 charger_thermal_state, const_current_timeout_state,
                 sys_min_voltage_state, charger_restart_state,
                 temp_zone_adjust_state, charger_reverse_state,
                 battery_voltage_reg_state, step_charge_state,
                 charger_dropout_state, sys_regulator_dropout_state,
                 link_voltage_present, sys_reverse_state,
                 link_connected_state, link_waiting_state, link_idle_state,
                 short_xfer_state, 2'b00, charger_mode_state, temp_zone_state};
    mon_chg = mon_rose | mon_fell;
  end

  change_detect #(
    .WIDTH(MON_W)
  ) u_change_detect (
    .clk_sys(clk_sys),
    .rst(rst),
    .level(mon_level),
    .rose(mon_rose),
    .fell(mon_fell)
  );

  // positions inside the monitored vector, M_TOP counted from the top, M_FIELDS from the bottom
  localparam int M_TOP = MON_W - 1;
  localparam int M_FIELDS = CHG_MODE_W + TEMP_ZONE_W;

  ////////////////////////////////////////////////////////////////////////////
  // per-register set terms

  logic [7:0] charger_set;
  logic [7:0] power_set;
  logic [7:0] link_set;

  always_comb begin
    charger_set = 8'h00;
    charger_set[SUM_LIMIT_ACTIVE_BIT] = mon_chg[M_TOP];
    charger_set[SUMMED_CURRENT_BIT] = mon_chg[M_TOP-1];
    charger_set[CHARGER_THERMAL_BIT] = mon_chg[M_TOP-2];
    charger_set[CONST_CURRENT_TIMEOUT_BIT] = mon_chg[M_TOP-3];
    // a field change is any bit of the field differing from last cycle
    charger_set[CHARGER_MODE_BIT] = |mon_chg[M_FIELDS-1:TEMP_ZONE_W];
    charger_set[SYS_MIN_VOLTAGE_BIT] = mon_chg[M_TOP-4];
    charger_set[CHARGER_RESTART_BIT] = mon_chg[M_TOP-5];
    charger_set[TEMP_ZONE_BIT] = |mon_chg[TEMP_ZONE_W-1:0];

    power_set = 8'h00;
    power_set[TEMP_ZONE_ADJUST_BIT] = mon_chg[M_TOP-6];
    power_set[CHARGER_REVERSE_BIT] = mon_chg[M_TOP-7];
    power_set[BATTERY_VOLTAGE_REG_BIT] = mon_chg[M_TOP-8];
    power_set[STEP_CHARGE_BIT] = mon_chg[M_TOP-9];
    power_set[CHARGER_DROPOUT_BIT] = mon_chg[M_TOP-10];
    power_set[SYS_REGULATOR_DROPOUT_BIT] = mon_chg[M_TOP-11];
    power_set[LINK_VOLTAGE_BIT] = mon_chg[M_TOP-12];
    power_set[SYS_REVERSE_BIT] = mon_chg[M_TOP-13];

    link_set = 8'h00;
    link_set[LINK_CONNECTED_BIT] = mon_chg[M_TOP-14];
    link_set[LINK_WAITING_BIT] = mon_chg[M_TOP-15];
    link_set[LINK_IDLE_BIT] = mon_chg[M_TOP-16];
    link_set[SHORT_XFER_RISE_BIT] = mon_rose[M_TOP-17];
    link_set[SHORT_XFER_FALL_BIT] = mon_fell[M_TOP-17];
    link_set[NEW_DATA_BIT] = new_data_stored;
    link_set[CMD_DONE_BIT] = cmd_done_pulse;
    link_set[CMD_ERROR_BIT] = cmd_error_pulse;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky flags, cleared by writing ones

  logic [7:0] charger_flags_reg;
  logic [7:0] charger_flags_next;
  logic [7:0] power_flags_reg;
  logic [7:0] power_flags_next;
  logic [7:0] link_flags_reg;
  logic [7:0] link_flags_next;
  logic [7:0] link_status_reg;
  logic [7:0] link_status_next;

  always_comb begin
    logic [7:0] clr_charger;
    logic [7:0] clr_power;
    logic [7:0] clr_link;
    clr_charger = 8'h00;
    clr_power = 8'h00;
    clr_link = 8'h00;
    if (reg_wr_en) begin
      unique case (reg_addr)
        CHARGER_EVENT_FLAGS_OFFSET: clr_charger = reg_wdata;
        POWER_PATH_EVENT_FLAGS_OFFSET: clr_power = reg_wdata;
        LINK_EVENT_FLAGS_OFFSET: clr_link = reg_wdata;
        default: clr_link = 8'h00;
      endcase
    end
    charger_flags_next = sticky_update(charger_flags_reg, charger_set, clr_charger);
    power_flags_next = sticky_update(power_flags_reg, power_set, clr_power);
    link_flags_next = sticky_update(link_flags_reg, link_set, clr_link);
    // the code is captured in the same edge that raises done or error, so it
    // is already valid when software sees either flag
    link_status_next = link_status_reg;
    if (cmd_done_pulse || cmd_error_pulse) begin
      link_status_next = cmd_result;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      charger_flags_reg <= FLAGS_RESET;
      power_flags_reg <= FLAGS_RESET;
      link_flags_reg <= FLAGS_RESET;
      link_status_reg <= LINK_STATUS_RESET;
    end else begin
      charger_flags_reg <= charger_flags_next;
      power_flags_reg <= power_flags_next;
      link_flags_reg <= link_flags_next;
      link_status_reg <= link_status_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path: data registered one cycle after the read strobe

  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd_en) begin
      unique case (reg_addr)
        CHARGER_EVENT_FLAGS_OFFSET: rdata_next = charger_flags_reg;
        POWER_PATH_EVENT_FLAGS_OFFSET: rdata_next = power_flags_reg;
        LINK_EVENT_FLAGS_OFFSET: rdata_next = link_flags_reg;
        LINK_STATUS_OFFSET: rdata_next = link_status_reg;
        default: rdata_next = UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_reg <= UNMAPPED_READ;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops

  logic unused_any;

  always_comb begin
    reg_rdata = rdata_reg;
    charger_event_flags = charger_flags_reg;
    power_path_event_flags = power_flags_reg;
    link_event_flags = link_flags_reg;
    link_status = link_status_reg;
    // the two padding positions of the monitored vector never change
    unused_any = any_bit({6'h00, mon_chg[M_FIELDS+1:M_FIELDS]});
  end

endmodule : event_flag_registers

`default_nettype wire

// File: test/event_flag_registers_chk.sv
// port assertions for the event flag register block
// assumes one clock domain and a synchronous active-high reset
`default_nettype none
module event_flag_registers_chk
  import event_flags_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [event_flags_pkg::REG_ADDR_W-1:0] reg_addr,
  input wire logic reg_rd_en,
  input wire logic [event_flags_pkg::REG_DATA_W-1:0] reg_rdata,
  input wire logic charger_thermal_state,
  input wire logic [event_flags_pkg::CHG_MODE_W-1:0] charger_mode_state,
  input wire logic [event_flags_pkg::TEMP_ZONE_W-1:0] temp_zone_state,
  input wire logic short_xfer_state,
  input wire logic new_data_stored,
  input wire logic cmd_done_pulse,
  input wire logic cmd_error_pulse,
  input wire logic [7:0] cmd_result,
  input wire logic reg_wr_en,
  input wire logic [7:0] charger_event_flags,
  input wire logic [7:0] link_event_flags,
  input wire logic [7:0] link_status
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  // the first edge after reset only captures levels, so it is excluded
  AST_THERMAL: assert property (!$past(rst) && $changed(charger_thermal_state)
    |=> charger_event_flags[5]) else $error("thermal change missed");
  AST_MODE: assert property (!$past(rst) && $changed(charger_mode_state)
    |=> charger_event_flags[3]) else $error("mode change missed");
  AST_ZONE: assert property (!$past(rst) && $changed(temp_zone_state)
    |=> charger_event_flags[0]) else $error("zone change missed");
  AST_RISE: assert property (!$past(rst) && $rose(short_xfer_state)
    |=> link_event_flags[4]) else $error("short transfer rise missed");
  AST_FALL: assert property (!$past(rst) && $fell(short_xfer_state)
    |=> link_event_flags[3]) else $error("short transfer fall missed");
  AST_NEW_DATA: assert property (new_data_stored |=> link_event_flags[2])
    else $error("new data flag missed");
  AST_DONE: assert property (cmd_done_pulse
    |=> link_event_flags[1] && link_status == $past(cmd_result)) else $error("done missed");
  AST_ERROR: assert property (cmd_error_pulse |=> link_event_flags[0])
    else $error("error flag missed");
  AST_STICKY: assert property (!(reg_wr_en && reg_addr == CHARGER_EVENT_FLAGS_OFFSET)
    |=> ($past(charger_event_flags) & ~charger_event_flags) == 8'h00)
    else $error("charger flag dropped without a clear");
  AST_READ: assert property (reg_rd_en && reg_addr == LINK_EVENT_FLAGS_OFFSET
    |=> reg_rdata == $past(link_event_flags)) else $error("link flag readback wrong");
  cover property (cmd_done_pulse ##1 link_event_flags[1]);
  cover property ($rose(short_xfer_state));
  cover property (reg_wr_en && reg_addr == CHARGER_EVENT_FLAGS_OFFSET);
endmodule : event_flag_registers_chk
bind event_flag_registers event_flag_registers_chk u_event_flag_registers_chk (.clk_sys,
  .rst, .reg_addr, .reg_rd_en, .reg_rdata, .charger_thermal_state, .charger_mode_state,
  .temp_zone_state, .short_xfer_state, .new_data_stored, .cmd_done_pulse, .cmd_error_pulse,
  .cmd_result, .reg_wr_en, .charger_event_flags, .link_event_flags, .link_status);
`default_nettype wire

// File: test/host_model.sv
// host side of the byte-wide register port
// assumes one-cycle strobes sampled on the rising edge of clk_sys
`default_nettype none
module host_model
  import event_flags_pkg::*;
(
  input wire logic clk_sys,
  output logic [7:0] reg_addr,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
  end
  // released address and data are inverted so stale values are never trusted
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= wr;
    reg_rd_en <= ~wr;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
    reg_rd_en <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1 q = reg_rdata;
  endtask : xfer
endmodule : host_model
`default_nettype wire

// File: test/event_flag_registers_tb.sv
// self-checking bench for the event flag register block
// assumes host_model owns the register port
`default_nettype none
module event_flag_registers_tb;
  import event_flags_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, cf, pf, lf, lst, rd;
  logic reg_wr_en, reg_rd_en;
  logic [11:0] cs = 12'h000;
  logic [7:0] ps = 8'h00, res = 8'h00, ec = 8'h00, ep = 8'h00, el = 8'h00;
  logic [3:0] ls = 4'h0;
  logic [2:0] ev = 3'h0;
  int miscompares = 0, num_checks = 0;
  always #5 clk_sys = ~clk_sys;
  host_model u_host_model (.clk_sys, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata,
    .reg_rdata);
  event_flag_registers u_event_flag_registers (.clk_sys, .rst, .reg_addr, .reg_wr_en,
    .reg_rd_en, .reg_wdata, .reg_rdata, .sum_limit_active_state(cs[11]),
    .summed_current_state(cs[10]), .charger_thermal_state(cs[9]),
    .const_current_timeout_state(cs[8]), .charger_mode_state(cs[7:5]),
    .sys_min_voltage_state(cs[4]), .charger_restart_state(cs[3]), .temp_zone_state(cs[2:0]),
    .temp_zone_adjust_state(ps[7]), .charger_reverse_state(ps[6]),
    .battery_voltage_reg_state(ps[5]), .step_charge_state(ps[4]),
    .charger_dropout_state(ps[3]), .sys_regulator_dropout_state(ps[2]),
    .link_voltage_present(ps[1]), .sys_reverse_state(ps[0]), .link_connected_state(ls[3]),
    .link_waiting_state(ls[2]), .link_idle_state(ls[1]), .short_xfer_state(ls[0]),
    .new_data_stored(ev[2]), .cmd_done_pulse(ev[1]), .cmd_error_pulse(ev[0]),
    .cmd_result(res), .charger_event_flags(cf), .power_path_event_flags(pf),
    .link_event_flags(lf), .link_status(lst));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] chg_flags(input logic [11:0] d);
    return {d[11:8], |d[7:5], d[4:3], |d[2:0]};
  endfunction : chg_flags
  function automatic logic [7:0] link_flags(input logic [3:0] o, input logic [3:0] n,
                                            input logic [2:0] e);
    return {o[3:1] ^ n[3:1], ~o[0] & n[0], o[0] & ~n[0], e};
  endfunction : link_flags
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // pulses last one cycle; levels hold until the next step
  task automatic step(input logic [11:0] nc, input logic [7:0] np, input logic [3:0] nl,
                      input logic [2:0] ne, input logic [7:0] nr);
    @(posedge clk_sys);
    ec = ec | chg_flags(cs ^ nc);
    ep = ep | (ps ^ np);
    el = el | link_flags(ls, nl, ne);
    cs <= nc;
    ps <= np;
    ls <= nl;
    ev <= ne;
    res <= nr;
    @(posedge clk_sys);
    ev <= 3'h0;
    @(posedge clk_sys);
    #1;
    check("charger flags", ec, cf);
    check("power flags", ep, pf);
    check("link flags", el, lf);
    if (ne[1:0] != 2'b00) check("link status", nr, lst);
  endtask : step
  task automatic read_clear(input logic [7:0] mask);
    for (int i = 0; i < 3; i++) begin
      u_host_model.xfer(1'b0, CHARGER_EVENT_FLAGS_OFFSET + 8'(i), 8'h00, rd);
      check("flag readback", i == 0 ? ec : (i == 1 ? ep : el), rd);
      u_host_model.xfer(1'b1, CHARGER_EVENT_FLAGS_OFFSET + 8'(i), mask, rd);
    end
    ec = ec & ~mask;
    ep = ep & ~mask;
    el = el & ~mask;
  endtask : read_clear
  task automatic finish_test;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h9db7));
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check("reset flags", FLAGS_RESET, cf | pf | lf | lst);
    step(12'hFFF, 8'hFF, 4'hF, 3'h7, 8'h10);
    u_host_model.xfer(1'b1, LINK_STATUS_OFFSET, 8'hFF, rd);
    u_host_model.xfer(1'b0, LINK_STATUS_OFFSET, 8'h00, rd);
    check("status readback", 8'h10, rd);
    u_host_model.xfer(1'b0, 8'h20, 8'h00, rd);
    check("unmapped read", UNMAPPED_READ, rd);
    read_clear(8'hFF);
    step(12'h000, 8'h00, 4'h0, 3'h1, 8'h1D);
    read_clear(8'h5A);
    // levels that move while reset is held must not raise flags once it is released
    @(posedge clk_sys);
    rst <= 1'b1;
    cs <= 12'h5A5;
    ps <= 8'hC3;
    ls <= 4'h9;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    check("flags after reset", FLAGS_RESET, cf | pf | lf | lst);
    check("read data after reset", 8'h00, reg_rdata);
    ec = 8'h00;
    ep = 8'h00;
    el = 8'h00;
    $display("corner tests done");
    for (int n = 0; n < 200; n++) begin
      step(12'($urandom), 8'($urandom), 4'($urandom), 3'($urandom), 8'($urandom));
      read_clear(8'($urandom));
    end
    $display("random tests done");
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    finish_test();
  end
endmodule : event_flag_registers_tb
`default_nettype wire
